//--- inc/alt_mode_switch_cfg.svh
`ifndef ALT_MODE_SWITCH_CFG_SVH
`define ALT_MODE_SWITCH_CFG_SVH
/*
 Offsets, field positions, reset values and widths of the switch configuration bank.
 Assumes inclusion by the package and by the design file; definitions only.
*/
// Summary of operation
// RULE1: The host leaves every offset outside the map alone, as those are reserved.
// RULE2: Mode bit 7 picks linear (0) or limited (1) redriving on the upstream transmitter.
// RULE3: Mode bit 5 picks the default (0) or the alternate (1) pin as hot-plug source.
// RULE4: While mode bit 5 is set the closed-chassis debug function is disabled.
// RULE5: Mode bit 4 picks strap-sampled (0) or register (1) equalization settings.
// RULE6: Mode bit 3 set forces the internal hot-plug input high, clear follows the pin.
// RULE7: Mode bit 2 picks normal (0) or flipped (1) connector orientation.
// RULE8: Mode bits 1-0 give off, USB only, four display lanes, or USB plus two lanes.
// RULE9: After reset the mode register holds 0x01.
// RULE10: Hardware-updated fields read back live device state, not the last write.
// RULE11: A write-one-to-set bit is set by writing 1 and unchanged by writing 0.
// RULE12: The host sends the register offset as one byte right after the write header.
// RULE13: With no offset written since reset, reads start at offset 00h and walk up.
// RULE14: The register pointer advances after every byte moved, acknowledged or not.
// RULE15: Reserved mode bit 6 reads as zero and ignores writes.

// register offsets
`define OFFS_MODE 8'h0a
`define OFFS_DBG 8'h0b
`define OFFS_DP01 8'h10
`define OFFS_DP23 8'h11
`define OFFS_AUX 8'h12
`define OFFS_DPLANE 8'h13
`define OFFS_AEQ1 8'h1c
`define OFFS_AEQ2 8'h1d
`define OFFS_AEQL 8'h1e
`define OFFS_USBC 8'h20
`define OFFS_SSEQ 8'h21
`define OFFS_MISC 8'h22
`define OFFS_USBST 8'h24
`define OFFS_VOD 8'h32
`define OFFS_AEQST 8'h3b

// mode register fields, debug-off select and restart bit of the misc register
`define B_LIMIT 7
`define B_SWAP 5
`define B_EQSRC 4
`define B_FORCE 3
`define B_FLIP 2
`define MODE_WMASK 8'hbf
`define DBG_OFF 2'h3
`define B_RESTART 0

// reset values and synchroniser width
`define MODE_RST 8'h01
`define DBG_RST 8'h6c
`define OTHER_RST 8'h00
`define ADDR_RST 7'h44
`define NSYNC 6
`endif

//--- inc/alt_mode_switch_pkg.sv
/*
 Types of the switch configuration bank: serial engine states and the state record.
 Assumes the cfg header is on the include path.
*/
package alt_mode_switch_pkg;
`include "alt_mode_switch_cfg.svh"

typedef enum logic [2:0] {
	st_idle = 3'b000,
	st_addr = 3'b001,
	st_ack_out = 3'b010,
	st_rx = 3'b011,
	st_tx = 3'b100,
	st_ack_in = 3'b101,
	st_wait = 3'b110
} ser_state_e;

typedef struct packed {
	logic [`NSYNC-1:0] s1;
	logic [`NSYNC-1:0] s2;
	logic [`NSYNC-1:0] s3;
	logic [`NSYNC-1:0] flt;
	logic [1:0] prv;
	ser_state_e state;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic [7:0] ptr;
	logic rw;
	logic nack;
	logic offs_pend;
	logic sda_oe;
	logic [7:0] mode_orientation_ctrl;
	logic [7:0] debug_and_tx_shaping_ctrl;
	logic [7:0] display_lane01_rx_eq;
	logic [7:0] display_lane23_rx_eq;
	logic [7:0] display_lane_enable_ctrl;
	logic [7:0] adaptive_eq_ctrl_a;
	logic [7:0] adaptive_eq_ctrl_b;
	logic [7:0] adaptive_eq_long_channel;
	logic [7:0] connector_rx_eq_ctrl;
	logic [7:0] upstream_rx_eq_ctrl;
	logic [7:0] usb_misc_ctrl;
	logic [7:0] swing_linearity_ctrl;
	logic hpd;
	logic [1:0] dbg_sel;
	logic [15:0] dp_eq;
} state_s;
endpackage

//--- verilog/alt_mode_switch_config_regs.sv
/*
 Configuration bank of the alternate-mode crosspoint switch with its serial
 two-wire target engine, hot-plug selection and equalization source selection.
 Assumes scl, sda, hot-plug and strap pins arrive asynchronously; the status
 inputs and the restart acknowledge come from logic on clk.
*/
`timescale 1ns/100ps
`include "alt_mode_switch_cfg.svh"

module alt_mode_switch_config_regs
	import alt_mode_switch_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = `ADDR_RST
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic hpd_pin,
	input wire logic hpd_alt_pin,
	input wire logic [1:0] eq_strap,
	input wire logic [7:0] aux_snoop_in,
	input wire logic [7:0] usb_fsm_in,
	input wire logic [7:0] aeq_result_in,
	input wire logic aeq_restart_ack,
	output logic [1:0] lane_config_select,
	output logic flip_orientation,
	output logic upstream_tx_limited_mode,
	output logic eq_source_register_select,
	output logic hotplug_input,
	output logic [1:0] closed_chassis_debug,
	output logic [5:0] tx_shaping,
	output logic [15:0] dp_lane_eq,
	output logic [7:0] dp_lane_enable,
	output logic aeq_restart
);

	state_s st_reg;
	state_s st_next;

	// reset image of the whole state
	localparam state_s RST_S = '{
		state: st_idle,
		mode_orientation_ctrl: `MODE_RST,
		debug_and_tx_shaping_ctrl: `DBG_RST,
		default: 0
	};

	// filtered bus lines and their edges
	logic scl_f;
	logic sda_f;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	assign scl_f = st_reg.flt[0];
	assign sda_f = st_reg.flt[1];
	assign scl_rise = scl_f & ~st_reg.prv[0];
	assign scl_fall = ~scl_f & st_reg.prv[0];
	assign start_c = scl_f & st_reg.prv[0] & ~sda_f & st_reg.prv[1];
	assign stop_c = scl_f & st_reg.prv[0] & sda_f & ~st_reg.prv[1];

	// read decode, unmapped offsets answer zero
	function automatic logic [7:0] rd(state_s s, logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		if (a == `OFFS_MODE) begin
			d = s.mode_orientation_ctrl & `MODE_WMASK; // RULE15
		end else if (a == `OFFS_DBG) begin
			d = s.debug_and_tx_shaping_ctrl;
		end else if (a == `OFFS_DP01) begin
			d = s.dp_eq[7:0]; // RULE10
		end else if (a == `OFFS_DP23) begin
			d = s.dp_eq[15:8]; // RULE10
		end else if (a == `OFFS_AUX) begin
			d = aux_snoop_in; // RULE10
		end else if (a == `OFFS_DPLANE) begin
			d = s.display_lane_enable_ctrl;
		end else if (a == `OFFS_AEQ1) begin
			d = s.adaptive_eq_ctrl_a;
		end else if (a == `OFFS_AEQ2) begin
			d = s.adaptive_eq_ctrl_b;
		end else if (a == `OFFS_AEQL) begin
			d = s.adaptive_eq_long_channel;
		end else if (a == `OFFS_USBC) begin
			d = s.connector_rx_eq_ctrl;
		end else if (a == `OFFS_SSEQ) begin
			d = s.upstream_rx_eq_ctrl;
		end else if (a == `OFFS_MISC) begin
			d = s.usb_misc_ctrl; // RULE10
		end else if (a == `OFFS_USBST) begin
			d = usb_fsm_in; // RULE10
		end else if (a == `OFFS_VOD) begin
			d = s.swing_linearity_ctrl;
		end else if (a == `OFFS_AEQST) begin
			d = aeq_result_in; // RULE10
		end
		return d;
	endfunction

	// write decode, read-only and unmapped offsets ignore the data
	function automatic state_s wr(state_s s, logic [7:0] a, logic [7:0] d);
		state_s o;
		o = s;
		if (a == `OFFS_MODE) begin
			o.mode_orientation_ctrl = d & `MODE_WMASK; // RULE15
		end else if (a == `OFFS_DBG) begin
			o.debug_and_tx_shaping_ctrl = d;
		end else if (a == `OFFS_DP01) begin
			o.display_lane01_rx_eq = d;
		end else if (a == `OFFS_DP23) begin
			o.display_lane23_rx_eq = d;
		end else if (a == `OFFS_DPLANE) begin
			o.display_lane_enable_ctrl = d;
		end else if (a == `OFFS_AEQ1) begin
			o.adaptive_eq_ctrl_a = d;
		end else if (a == `OFFS_AEQ2) begin
			o.adaptive_eq_ctrl_b = d;
		end else if (a == `OFFS_AEQL) begin
			o.adaptive_eq_long_channel = d;
		end else if (a == `OFFS_USBC) begin
			o.connector_rx_eq_ctrl = d;
		end else if (a == `OFFS_SSEQ) begin
			o.upstream_rx_eq_ctrl = d;
		end else if (a == `OFFS_MISC) begin
			o.usb_misc_ctrl[7:1] = d[7:1];
			o.usb_misc_ctrl[`B_RESTART] = s.usb_misc_ctrl[`B_RESTART] | d[`B_RESTART]; // RULE11
		end else if (a == `OFFS_VOD) begin
			o.swing_linearity_ctrl = d;
		end
		return o;
	endfunction

	// next state: synchronisers, serial engine, derived outputs
	always_comb begin
		logic [7:0] b;
		b = rd(st_reg, st_reg.ptr);
		st_next = st_reg;
		st_next.s1 = {eq_strap, hpd_alt_pin, hpd_pin, sda_in, scl_in};
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < `NSYNC; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.flt[i] = st_reg.s3[i];
			end
		end
		st_next.prv = st_reg.flt[1:0];
		// hardware clear first, so a write of one in the same cycle wins
		if (aeq_restart_ack) begin
			st_next.usb_misc_ctrl[`B_RESTART] = 1'b0;
		end
		case (st_reg.state)
			st_addr, st_rx: begin
				if (scl_rise) begin
					st_next.sh = {st_reg.sh[6:0], sda_f};
					st_next.cnt = st_reg.cnt + 4'h1;
				end else if (scl_fall && st_reg.cnt == 4'h8) begin
					st_next.state = st_ack_out;
					st_next.sda_oe = 1'b1;
					if (st_reg.state == st_addr) begin
						if (st_reg.sh[7:1] == TARGET_ADDR) begin
							st_next.rw = st_reg.sh[0];
							st_next.offs_pend = ~st_reg.sh[0];
						end else begin
							st_next.state = st_wait;
							st_next.sda_oe = 1'b0;
						end
					end else if (st_reg.offs_pend) begin
						st_next.ptr = st_reg.sh; // RULE12
						st_next.offs_pend = 1'b0;
					end else begin
						st_next = wr(st_next, st_reg.ptr, st_reg.sh);
						st_next.ptr = st_reg.ptr + 8'h01; // RULE14
					end
				end
			end
			st_ack_out: begin
				if (scl_fall) begin
					st_next.cnt = 4'h0;
					if (st_reg.rw) begin
						st_next.state = st_tx;
						st_next.sh = b;
						st_next.sda_oe = ~b[7];
						st_next.cnt = 4'h1;
						st_next.ptr = st_reg.ptr + 8'h01; // RULE13 RULE14
					end else begin
						st_next.state = st_rx;
						st_next.sda_oe = 1'b0;
					end
				end
			end
			st_tx: begin
				if (scl_fall) begin
					if (st_reg.cnt == 4'h8) begin
						st_next.state = st_ack_in;
						st_next.sda_oe = 1'b0;
					end else begin
						st_next.sh = {st_reg.sh[6:0], 1'b0};
						st_next.sda_oe = ~st_reg.sh[6];
						st_next.cnt = st_reg.cnt + 4'h1;
					end
				end
			end
			st_ack_in: begin
				if (scl_rise) begin
					st_next.nack = sda_f;
				end else if (scl_fall) begin
					if (st_reg.nack) begin
						st_next.state = st_wait;
					end else begin
						st_next.state = st_tx;
						st_next.sh = b;
						st_next.sda_oe = ~b[7];
						st_next.cnt = 4'h1;
						st_next.ptr = st_reg.ptr + 8'h01; // RULE14
					end
				end
			end
			default: begin
				st_next.sda_oe = 1'b0;
			end
		endcase
		// start and stop override any state, a repeated start included
		if (start_c) begin
			st_next.state = st_addr;
			st_next.cnt = 4'h0;
			st_next.sda_oe = 1'b0;
		end else if (stop_c) begin
			st_next.state = st_idle;
			st_next.sda_oe = 1'b0;
		end
		// hot-plug source: force, else default or swapped pin
		if (st_next.mode_orientation_ctrl[`B_FORCE]) begin
			st_next.hpd = 1'b1; // RULE6
		end else if (st_next.mode_orientation_ctrl[`B_SWAP]) begin
			st_next.hpd = st_reg.flt[3]; // RULE3
		end else begin
			st_next.hpd = st_reg.flt[2]; // RULE3
		end
		// pin swap takes the debug function down
		if (st_next.mode_orientation_ctrl[`B_SWAP]) begin
			st_next.dbg_sel = `DBG_OFF; // RULE4
		end else begin
			st_next.dbg_sel = st_next.debug_and_tx_shaping_ctrl[1:0];
		end
		// equalization from registers or from the strap pins
		if (st_next.mode_orientation_ctrl[`B_EQSRC]) begin
			st_next.dp_eq = {st_next.display_lane23_rx_eq, st_next.display_lane01_rx_eq}; // RULE5
		end else begin
			st_next.dp_eq = {4{2'b00, st_reg.flt[5:4]}}; // RULE5
		end
	end

	// single state register, synchronous reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= RST_S; // RULE9 RULE13
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs taken straight from the state register, sda_out tied low
	assign sda_out = 1'b0;
	assign sda_oe = st_reg.sda_oe;
	assign lane_config_select = st_reg.mode_orientation_ctrl[1:0]; // RULE8
	assign flip_orientation = st_reg.mode_orientation_ctrl[`B_FLIP]; // RULE7
	assign upstream_tx_limited_mode = st_reg.mode_orientation_ctrl[`B_LIMIT]; // RULE2
	assign eq_source_register_select = st_reg.mode_orientation_ctrl[`B_EQSRC];
	assign hotplug_input = st_reg.hpd;
	assign closed_chassis_debug = st_reg.dbg_sel;
	assign tx_shaping = st_reg.debug_and_tx_shaping_ctrl[7:2];
	assign dp_lane_eq = st_reg.dp_eq;
	assign dp_lane_enable = st_reg.display_lane_enable_ctrl;
	assign aeq_restart = st_reg.usb_misc_ctrl[`B_RESTART];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// a byte handed out to the host
	sequence byte_load;
		(st_reg.state == st_ack_out && st_reg.rw && scl_fall) ||
		(st_reg.state == st_ack_in && !st_reg.nack && scl_fall);
	endsequence

	sequence mode_written;
		st_reg.state == st_rx && scl_fall && st_reg.cnt == 4'h8 &&
		!st_reg.offs_pend && st_reg.ptr == `OFFS_MODE;
	endsequence

	mode_reset_val_a: assert property ($rose(rst_n) |-> // RULE9
		st_reg.mode_orientation_ctrl == `MODE_RST && st_reg.ptr == 8'h00)
		else $error("bad reset state");
	ptr_advance_a: assert property (byte_load |=> // RULE14
		st_reg.ptr == $past(st_reg.ptr) + 8'h01)
		else $error("pointer did not advance");
	rsvd_bit_a: assert property (mode_written |=> // RULE15
		upstream_tx_limited_mode == $past(st_reg.sh[7]) &&
		st_reg.mode_orientation_ctrl[6] == 1'b0)
		else $error("mode write wrong");
	// hot-plug output is registered together with the mode bits
	hpd_force_a: assert property (st_reg.mode_orientation_ctrl[`B_FORCE] |-> // RULE6
		hotplug_input)
		else $error("hot-plug not forced");
	// pin levels reach the output one cycle after the filter
	hpd_select_a: assert property (!st_reg.mode_orientation_ctrl[`B_FORCE] |-> // RULE3
		hotplug_input == (st_reg.mode_orientation_ctrl[`B_SWAP] ?
		$past(st_reg.flt[3]) : $past(st_reg.flt[2])))
		else $error("hot-plug source wrong");
	debug_off_a: assert property (st_reg.mode_orientation_ctrl[`B_SWAP] |-> // RULE4
		closed_chassis_debug == `DBG_OFF)
		else $error("debug not disabled");
	eq_source_a: assert property (st_reg.mode_orientation_ctrl[`B_EQSRC] |-> // RULE5
		dp_lane_eq == {st_reg.display_lane23_rx_eq, st_reg.display_lane01_rx_eq})
		else $error("eq source wrong");
	w1s_hold_a: assert property (aeq_restart && !aeq_restart_ack |=> aeq_restart) // RULE11
		else $error("set bit lost");
	lane_change_a: assert property ($changed(lane_config_select) |-> // RULE8
		$past(st_reg.state) == st_rx)
		else $error("lane change without write");
endmodule

//--- test/i2c_host_model.sv
/*
 Two-wire host that configures the switch bank, with tasks for start, stop and bytes.
 Assumes an external pull-up on the data line; the host only pulls it low.
*/
`timescale 1ns/100ps

module i2c_host_model (
	input wire logic clk,
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	// bus idle: both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// wait n clocks, then move just after the edge
	task automatic hw(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// start or repeated start, data falls while clock high
	task automatic start();
		sda_low = 1'b0;
		hw(8);
		scl = 1'b1;
		hw(10);
		sda_low = 1'b1;
		hw(10);
		scl = 1'b0;
		hw(10);
	endtask

	// stop, data rises while clock high
	task automatic stop();
		sda_low = 1'b1;
		hw(8);
		scl = 1'b1;
		hw(10);
		sda_low = 1'b0;
		hw(10);
	endtask

	// one bit, sampled mid high phase, data held past the fall
	task automatic xbit(input logic b, output logic r);
		sda_low = !b;
		hw(8);
		scl = 1'b1;
		hw(5);
		r = sda;
		hw(5);
		scl = 0;
		hw(2);
	endtask

	// byte out msb first, ack returned high when the device pulled low
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], r);
		end
		xbit(1'b1, r);
		ack = !r;
	endtask

	// byte in msb first, then host ack or nack
	task automatic rd_byte(output logic [7:0] d, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xbit(1'b1, d[i]);
		end
		xbit(!ack, r);
	endtask
endmodule

//--- test/testbench.sv
/*
 Self-checking bench of the switch configuration bank driven over the two-wire bus.
 Assumes the host model beside it and the default target address.
*/
`timescale 1ns/100ps
`include "alt_mode_switch_cfg.svh"

module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic host_scl, host_low, sda_line, dev_out, dev_oe;
	logic hpd_pin = 1'b1;
	logic hpd_alt_pin = 1'b0;
	logic [1:0] eq_strap = 2'h1;
	logic [7:0] aux_in = 8'h00, usb_in = 8'h00, aeq_in = 8'h00;
	logic restart_ack = 1'b0;
	logic [1:0] lane, dbg;
	logic flip, limited, eq_sel, hotplug, restart;
	logic [5:0] shaping;
	logic [15:0] lane_eq;
	logic [7:0] lane_en;
	int n_fail = 0;
	int n_tests = 0;

	// clock and open-drain data line with pull-up
	always #50 clk = ~clk;
	assign sda_line = ~(host_low | (dev_oe & ~dev_out));

	i2c_host_model host (.clk(clk), .scl(host_scl), .sda_low(host_low), .sda(sda_line));

	alt_mode_switch_config_regs uut (.clk(clk), .rst_n(rst_n), .scl_in(host_scl),
		.sda_in(sda_line), .sda_out(dev_out), .sda_oe(dev_oe), .hpd_pin(hpd_pin),
		.hpd_alt_pin(hpd_alt_pin), .eq_strap(eq_strap), .aux_snoop_in(aux_in),
		.usb_fsm_in(usb_in), .aeq_result_in(aeq_in), .aeq_restart_ack(restart_ack),
		.lane_config_select(lane), .flip_orientation(flip),
		.upstream_tx_limited_mode(limited), .eq_source_register_select(eq_sel),
		.hotplug_input(hotplug), .closed_chassis_debug(dbg), .tx_shaping(shaping),
		.dp_lane_eq(lane_eq), .dp_lane_enable(lane_en), .aeq_restart(restart));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// header and offset, each acknowledged
	task automatic hdr(input logic [7:0] o);
		logic a;
		host.start();
		host.wr_byte(8'h88, a);
		chk(a, 1'b1);
		host.wr_byte(o, a);
		chk(a, 1'b1);
	endtask

	task automatic wr_reg(input logic [7:0] o, input logic [7:0] d);
		logic a;
		hdr(o);
		host.wr_byte(d, a);
		chk(a, 1'b1);
		host.stop();
	endtask

	// offset write, repeated start, one byte read with nack
	task automatic rd_reg(input logic [7:0] o, output logic [7:0] d);
		logic a;
		hdr(o);
		host.start();
		host.wr_byte(8'h89, a);
		chk(a, 1'b1);
		host.rd_byte(d, 1'b0);
		host.stop();
	endtask

	// first read after reset walks up from offset zero
	task automatic t_reset();
		logic a;
		logic [7:0] d;
		chk({lane, flip, limited, eq_sel}, 5'h08);
		chk(shaping, 6'h1b);
		host.start();
		host.wr_byte(8'h89, a);
		chk(a, 1'b1);
		for (int i = 0; i < 12; i++) begin
			host.rd_byte(d, i < 11);
			chk(d, i == 10 ? `MODE_RST : (i == 11 ? `DBG_RST : 8'h00));
		end
		host.stop();
		$display("t_reset done");
	endtask

	// every lane config and mode bit, reserved bit masked
	task automatic t_mode();
		logic [7:0] mv [5] = '{8'h00, 8'h21, 8'h56, 8'hff, 8'h01};
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			wr_reg(`OFFS_MODE, mv[i]);
			rd_reg(`OFFS_MODE, d);
			chk(d, mv[i] & 8'hbf);
			chk(lane, mv[i][1:0]);
			chk(flip, mv[i][2]);
			chk(limited, mv[i][7]);
			chk(eq_sel, mv[i][4]);
			chk(hotplug, mv[i][3] ? 1'b1 : (mv[i][5] ? hpd_alt_pin : hpd_pin));
			chk(dbg, mv[i][5] ? 2'h3 : 2'h0);
		end
		$display("t_mode done");
	endtask

	// strap-sourced eq reads live, then burst write and register source
	task automatic t_eq();
		logic a;
		logic [7:0] d;
		rd_reg(`OFFS_DP01, d);
		chk(d, 8'h11);
		chk(lane_eq, 16'h1111);
		eq_strap = 2'h2;
		rd_reg(`OFFS_DP23, d);
		chk(d, 8'h22);
		hdr(`OFFS_DP01);
		host.wr_byte(8'h5a, a);
		host.wr_byte(8'hc3, a);
		host.stop();
		wr_reg(`OFFS_MODE, 8'h11);
		chk(lane_eq, 16'hc35a);
		$display("t_eq done");
	endtask

	// read-only status follows the hardware
	task automatic t_status();
		logic [7:0] d;
		aux_in = 8'h3c;
		usb_in = 8'ha5;
		aeq_in = 8'h96;
		rd_reg(`OFFS_AUX, d);
		chk(d, 8'h3c);
		rd_reg(`OFFS_USBST, d);
		chk(d, 8'ha5);
		rd_reg(`OFFS_AEQST, d);
		chk(d, 8'h96);
		usb_in = 8'h5a;
		rd_reg(`OFFS_USBST, d);
		chk(d, 8'h5a);
		wr_reg(`OFFS_DPLANE, 8'h0f);
		chk(lane_en, 8'h0f);
		rd_reg(`OFFS_DPLANE, d);
		chk(d, 8'h0f);
		wr_reg(`OFFS_DBG, 8'h92);
		chk(dbg, 2'h2);
		chk(shaping, 6'h24);
		$display("t_status done");
	endtask

	// set by a one, kept by a zero, cleared by the acknowledge
	task automatic t_w1s();
		wr_reg(`OFFS_MISC, 8'h01);
		chk(restart, 1'b1);
		wr_reg(`OFFS_MISC, 8'h00);
		chk(restart, 1'b1);
		@(posedge clk);
		#1 restart_ack = 1'b1;
		@(posedge clk);
		#1 restart_ack = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(restart, 1'b0);
		$display("t_w1s done");
	endtask

	// watchdog on the whole run
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		end_of_test();
	end

	// reset, settle, then the scenarios
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		t_reset();
		t_mode();
		t_eq();
		t_status();
		t_w1s();
		end_of_test();
	end
endmodule
